/* inc/wake_cdr_map.vh */
// register offsets, field positions and reset values of the wake recovery register slice
`ifndef WAKE_CDR_MAP_VH
`define WAKE_CDR_MAP_VH
`define ADDR_OSC_CALIB_HIGH 7'h3A
`define ADDR_OSC_CALIB_LOW 7'h3B
`define ADDR_RECOVERY_CONTROL_ONE 7'h3C
`define ADDR_RECOVERY_CONTROL_TWO 7'h3D
`define ADDR_BIT_TIME_UPPER_LIMIT 7'h3E
`define ADDR_BIT_TIME_LOWER_LIMIT 7'h3F
`define RST_OSC_CALIB 8'h00
`define RST_RECOVERY_CONTROL_ONE 8'h04
`define RST_RECOVERY_CONTROL_TWO 8'h00
`define RST_UPPER_LIMIT 8'hA8
`define RST_LOWER_LIMIT 8'h98
`define MASK_RECOVERY_CONTROL_ONE 8'h0D
`define MASK_RECOVERY_CONTROL_TWO 8'h03
`define BIT_RECOVERY_ENABLE 0
`define FILTER_SEL_HI 3
`define FILTER_SEL_LO 2
`define CLOCK_SEL_HI 1
`define CLOCK_SEL_LO 0
`define FRAME_BITS 16
`define ACCESS_BIT 7
`define TC_8 6'h08
`define TC_16 6'h10
`define TC_32 6'h20
`endif

/* core/wake_cdr_spi_shift.v */
// spi slave shifter: samples pins, assembles 16-bit frames, shifts out read data
`timescale 1ns/1ns
`default_nettype none
`include "wake_cdr_map.vh"
module wake_cdr_spi_shift (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire spi_clk_i,
  input wire spi_cs_n_i,
  input wire spi_mosi_i,
  input wire [7:0] read_data_i,
  output reg spi_miso_o,
  output reg spi_miso_oe_o,
  output reg [6:0] addr_o,
  output reg access_o,
  output reg addr_valid_o,
  output reg [7:0] data_o,
  output reg frame_done_o
);
  reg [2:0] sclk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [4:0] count_reg;
  reg [15:0] shift_reg;
  reg [7:0] out_reg;
  wire rise;
  wire fall;
  wire active;
  // first stage of each synchroniser feeds only its second stage
  assign rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign active = ~cs_sync_reg[1];
  //////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; spi clock is only a sampled input here
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_clk_i};
      cs_sync_reg <= {cs_sync_reg[0], spi_cs_n_i};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi_i};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // frame shifter, lsb first: bits 0..6 address, 7 access, 8..15 data
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count_reg <= 5'h00;
      shift_reg <= 16'h0000;
      out_reg <= 8'h00;
      addr_o <= 7'h00;
      access_o <= 1'b0;
      addr_valid_o <= 1'b0;
      data_o <= 8'h00;
      frame_done_o <= 1'b0;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      addr_valid_o <= 1'b0;
      frame_done_o <= 1'b0;
      spi_miso_oe_o <= active;
      if (!active) begin
        // a short frame is dropped whole
        count_reg <= 5'h00;
      end else if (rise && count_reg != 5'h10) begin
        shift_reg <= {mosi_sync_reg[1], shift_reg[15:1]};
        count_reg <= count_reg + 5'h01;
        if (count_reg == 5'h07) begin
          // first byte in: address and access bit known
          addr_o <= shift_reg[15:9];
          access_o <= mosi_sync_reg[1];
          addr_valid_o <= 1'b1;
        end
        if (count_reg == 5'h0F) begin
          // data bits d0..d7 sit at frame bits 8..15
          data_o <= {mosi_sync_reg[1], shift_reg[15:9]};
          frame_done_o <= 1'b1;
        end
      end else if (fall) begin
        if (count_reg == 5'h08) begin
          out_reg <= {1'b0, read_data_i[7:1]};
          spi_miso_o <= read_data_i[0];
        end else begin
          out_reg <= {1'b0, out_reg[7:1]};
          spi_miso_o <= out_reg[0];
        end
      end
    end
  end
endmodule // wake_cdr_spi_shift
`default_nettype wire

/* core/wake_cdr_config_regs.v */
// wake clock-data-recovery configuration registers behind a 16-bit spi frame
`timescale 1ns/1ns
`default_nettype none
`include "wake_cdr_map.vh"
module wake_cdr_config_regs #(
  parameter SPACING_WIDTH = 4
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire soft_reset_i,
  input wire spi_clk_i,
  input wire spi_cs_n_i,
  input wire spi_mosi_i,
  input wire calib_valid_i,
  input wire [7:0] calib_result_high_i,
  input wire [7:0] calib_result_low_i,
  input wire edge_spacing_valid_i,
  input wire [SPACING_WIDTH-1:0] edge_spacing_i,
  input wire measured_valid_i,
  input wire [7:0] measured_bit_time_i,
  output reg spi_miso_o,
  output reg spi_miso_oe_o,
  output reg recovery_enable_o,
  output reg [5:0] filter_time_constant_o,
  output reg [1:0] recovery_clock_select_o,
  output reg [6:0] recovery_clock_mhz_o,
  output reg [7:0] upper_bit_time_limit_o,
  output reg [7:0] lower_bit_time_limit_o,
  output reg [7:0] clamped_bit_time_o,
  output reg clamped_valid_o
);
  reg [7:0] osc_calib_high_reg;
  reg [7:0] osc_calib_low_reg;
  reg [7:0] recovery_control_one_reg;
  reg [7:0] recovery_control_two_reg;
  reg [7:0] bit_time_upper_limit_reg;
  reg [7:0] bit_time_lower_limit_reg;
  reg [5:0] adapt_constant_reg;
  reg [7:0] read_data_next;
  wire miso_w;
  wire miso_oe_w;
  wire [6:0] frame_addr;
  wire frame_access;
  wire frame_addr_valid;
  wire [7:0] frame_data;
  wire frame_done;
  wire [1:0] filter_sel;

  //////////////////////////////////////////////////////////////////////////
  // fixed filter codes map straight to a constant
  function [5:0] fixed_constant;
    input [1:0] code;
    begin
      case (code)
        2'h0: fixed_constant = `TC_8;
        2'h1: fixed_constant = `TC_16;
        default: fixed_constant = `TC_32;
      endcase
    end
  endfunction

  // clock select to rate in mhz
  function [6:0] clock_mhz;
    input [1:0] code;
    begin
      case (code)
        2'h0: clock_mhz = 7'h50;
        2'h1: clock_mhz = 7'h28;
        2'h2: clock_mhz = 7'h14;
        default: clock_mhz = 7'h0A;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  wake_cdr_spi_shift u_shift (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .spi_clk_i(spi_clk_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_mosi_i(spi_mosi_i),
    .read_data_i(read_data_next),
    .spi_miso_o(miso_w),
    .spi_miso_oe_o(miso_oe_w),
    .addr_o(frame_addr),
    .access_o(frame_access),
    .addr_valid_o(frame_addr_valid),
    .data_o(frame_data),
    .frame_done_o(frame_done)
  );

  assign filter_sel = recovery_control_one_reg[`FILTER_SEL_HI:`FILTER_SEL_LO];

  //////////////////////////////////////////////////////////////////////////
  // read mux, sampled by the shifter when the data byte begins
  always @* begin
    case (frame_addr)
      `ADDR_OSC_CALIB_HIGH: read_data_next = osc_calib_high_reg;
      `ADDR_OSC_CALIB_LOW: read_data_next = osc_calib_low_reg;
      `ADDR_RECOVERY_CONTROL_ONE: read_data_next = recovery_control_one_reg;
      `ADDR_RECOVERY_CONTROL_TWO: read_data_next = recovery_control_two_reg;
      `ADDR_BIT_TIME_UPPER_LIMIT: read_data_next = bit_time_upper_limit_reg;
      `ADDR_BIT_TIME_LOWER_LIMIT: read_data_next = bit_time_lower_limit_reg;
      default: read_data_next = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // calibration results: only hardware updates them, a clear frame leaves
  // them alone because every bit is read-only
  always @(posedge core_clk_i) begin
    if (!rst_n_i || soft_reset_i) begin
      osc_calib_high_reg <= `RST_OSC_CALIB;
      osc_calib_low_reg <= `RST_OSC_CALIB;
    end else if (calib_valid_i) begin
      // held until the next calibration, never auto-cleared
      osc_calib_high_reg <= calib_result_high_i;
      osc_calib_low_reg <= calib_result_low_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control writes take effect at frame end; access bit 1 writes control
  // registers, access bit 0 is a plain read
  always @(posedge core_clk_i) begin
    if (!rst_n_i || soft_reset_i) begin
      recovery_control_one_reg <= `RST_RECOVERY_CONTROL_ONE;
      recovery_control_two_reg <= `RST_RECOVERY_CONTROL_TWO;
      bit_time_upper_limit_reg <= `RST_UPPER_LIMIT;
      bit_time_lower_limit_reg <= `RST_LOWER_LIMIT;
    end else if (frame_done && frame_access) begin
      case (frame_addr)
        `ADDR_RECOVERY_CONTROL_ONE:
          recovery_control_one_reg <= frame_data & `MASK_RECOVERY_CONTROL_ONE;
        `ADDR_RECOVERY_CONTROL_TWO:
          recovery_control_two_reg <= frame_data & `MASK_RECOVERY_CONTROL_TWO;
        `ADDR_BIT_TIME_UPPER_LIMIT: bit_time_upper_limit_reg <= frame_data;
        `ADDR_BIT_TIME_LOWER_LIMIT: bit_time_lower_limit_reg <= frame_data;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // adaptive constant tracks falling edge spacing in bits; spacings
  // outside 2..10 keep the previous choice rather than guess
  always @(posedge core_clk_i) begin
    if (!rst_n_i || soft_reset_i) begin
      adapt_constant_reg <= `TC_16;
    end else if (edge_spacing_valid_i) begin
      if (edge_spacing_i >= 2 && edge_spacing_i <= 3) begin
        adapt_constant_reg <= `TC_32;
      end else if (edge_spacing_i >= 4 && edge_spacing_i <= 8) begin
        adapt_constant_reg <= `TC_16;
      end else if (edge_spacing_i >= 9 && edge_spacing_i <= 10) begin
        adapt_constant_reg <= `TC_8;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs toward the recovery datapath
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
      recovery_enable_o <= 1'b0;
      filter_time_constant_o <= `TC_16;
      recovery_clock_select_o <= 2'h0;
      recovery_clock_mhz_o <= 7'h50;
      upper_bit_time_limit_o <= `RST_UPPER_LIMIT;
      lower_bit_time_limit_o <= `RST_LOWER_LIMIT;
      clamped_bit_time_o <= 8'h00;
      clamped_valid_o <= 1'b0;
    end else begin
      spi_miso_o <= miso_w;
      spi_miso_oe_o <= miso_oe_w;
      recovery_enable_o <= recovery_control_one_reg[`BIT_RECOVERY_ENABLE];
      if (filter_sel == 2'h3) begin
        filter_time_constant_o <= adapt_constant_reg;
      end else begin
        filter_time_constant_o <= fixed_constant(filter_sel);
      end
      recovery_clock_select_o <= recovery_control_two_reg[`CLOCK_SEL_HI:`CLOCK_SEL_LO];
      recovery_clock_mhz_o <= clock_mhz(recovery_control_two_reg[1:0]);
      upper_bit_time_limit_o <= bit_time_upper_limit_reg;
      lower_bit_time_limit_o <= bit_time_lower_limit_reg;
      // clamp every cycle, valid only while recovery runs; limits are the plus/minus 5% window
      clamped_valid_o <= measured_valid_i & recovery_control_one_reg[0];
      if (measured_bit_time_i > bit_time_upper_limit_reg) begin
        clamped_bit_time_o <= bit_time_upper_limit_reg;
      end else if (measured_bit_time_i < bit_time_lower_limit_reg) begin
        clamped_bit_time_o <= bit_time_lower_limit_reg;
      end else begin
        clamped_bit_time_o <= measured_bit_time_i;
      end
    end
  end
endmodule // wake_cdr_config_regs
`default_nettype wire

/* testbench/wake_cdr_spi_host.sv */
// spi host model: 16-bit mode 0 frames, lsb first
`timescale 1ns/1ns
`default_nettype none
module wake_cdr_spi_host #(
  parameter HALF_NS = 200
) (
  input wire logic spi_miso_i,
  output logic spi_clk_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o
);
  // link clock stands low and select high between frames
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  ////////////////////////////////////////
  // address, access bit, then data; reply in frame bits 8 to 15
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rx);
    spi_cs_n_o = 1'b0;
    for (int i = 0; i < 16; i++) begin
      spi_mosi_o = frame[i];
      #(HALF_NS) spi_clk_o = 1'b1;
      #(HALF_NS - 10);
      if (i > 7) rx[i-8] = spi_miso_i; // late: reply trails the pin edge
      #10 spi_clk_o = 1'b0;
    end
    #(HALF_NS) spi_cs_n_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o; // released line keeps no useful level
    #(2 * HALF_NS);
  endtask
endmodule // wake_cdr_spi_host
`default_nettype wire

/* testbench/wake_cdr_config_regs_monitor.sv */
// port assertions for the wake recovery register slice
`timescale 1ns/1ns
`default_nettype none
module wake_cdr_config_regs_monitor (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic soft_reset_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_oe_o,
  input wire logic measured_valid_i,
  input wire logic [7:0] measured_bit_time_i,
  input wire logic recovery_enable_o,
  input wire logic [5:0] filter_time_constant_o,
  input wire logic [1:0] recovery_clock_select_o,
  input wire logic [6:0] recovery_clock_mhz_o,
  input wire logic [7:0] upper_bit_time_limit_o,
  input wire logic [7:0] lower_bit_time_limit_o,
  input wire logic [7:0] clamped_bit_time_o,
  input wire logic clamped_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] idle_cnt;
  logic [7:0] prev_time;
  ////////////////////////////////////////
  // quiet cycles since the last frame; a write lands within a few
  always @(posedge core_clk_i) begin
    prev_time <= measured_bit_time_i;
    if (!rst_n_i || !spi_cs_n_i) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != 4'hF) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end
  sequence s_soft; soft_reset_i [*2]; endsequence
  property p_soft_defaults;
    s_soft |=> upper_bit_time_limit_o == 8'hA8 && lower_bit_time_limit_o == 8'h98
      && filter_time_constant_o == 6'h10 && !recovery_enable_o && recovery_clock_select_o == 2'h0;
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("soft defaults");
  property p_hold;
    idle_cnt > 4'h9 && !$past(soft_reset_i) && !$past(soft_reset_i, 2) |->
      $stable(recovery_enable_o) && $stable(upper_bit_time_limit_o) && $stable(lower_bit_time_limit_o);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved");
  property p_enable_pulse;
    !soft_reset_i |=> clamped_valid_o == ($past(measured_valid_i) && recovery_enable_o);
  endproperty
  a_enable_pulse: assert property (p_enable_pulse) else $error("clamp pulse");
  property p_clamp_high;
    clamped_valid_o && prev_time > upper_bit_time_limit_o |->
      clamped_bit_time_o == upper_bit_time_limit_o;
  endproperty
  a_clamp_high: assert property (p_clamp_high) else $error("upper clamp");
  property p_clamp_low;
    clamped_valid_o && prev_time < lower_bit_time_limit_o |->
      clamped_bit_time_o == lower_bit_time_limit_o;
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("lower clamp");
  property p_clamp_pass;
    clamped_valid_o && prev_time <= upper_bit_time_limit_o && prev_time >= lower_bit_time_limit_o
      |-> clamped_bit_time_o == prev_time;
  endproperty
  a_clamp_pass: assert property (p_clamp_pass) else $error("clamp pass");
  property p_clock_rate; recovery_clock_mhz_o == 7'h50 >> recovery_clock_select_o; endproperty
  a_clock_rate: assert property (p_clock_rate) else $error("clock rate");
  property p_filter; filter_time_constant_o inside {6'h08, 6'h10, 6'h20}; endproperty
  a_filter: assert property (p_filter) else $error("filter constant");
  // select pin reaches the enable through two sync flops and two output flops
  property p_oe_follows_select;
    $past(rst_n_i, 4) |-> spi_miso_oe_o == !$past(spi_cs_n_i, 4);
  endproperty
  a_oe_follows_select: assert property (p_oe_follows_select) else $error("output enable");
endmodule // wake_cdr_config_regs_monitor
bind wake_cdr_config_regs wake_cdr_config_regs_monitor monitor_u (.core_clk_i, .rst_n_i,
  .soft_reset_i, .spi_cs_n_i, .spi_miso_oe_o, .measured_valid_i, .measured_bit_time_i,
  .recovery_enable_o,
  .filter_time_constant_o, .recovery_clock_select_o, .recovery_clock_mhz_o,
  .upper_bit_time_limit_o, .lower_bit_time_limit_o, .clamped_bit_time_o, .clamped_valid_o);
`default_nettype wire

/* testbench/wake_cdr_config_regs_bench.sv */
// self-checking bench for the wake recovery register slice
`timescale 1ns/1ns
`default_nettype none
module wake_cdr_config_regs_bench;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, soft_reset_i = 1'b0, calib_valid_i = 1'b0;
  logic edge_spacing_valid_i = 1'b0, measured_valid_i = 1'b0;
  logic [7:0] calib_result_high_i = 8'h00, calib_result_low_i = 8'h00, measured_bit_time_i = 8'h00;
  logic [3:0] edge_spacing_i = 4'h0;
  wire logic spi_clk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o, recovery_enable_o;
  wire logic clamped_valid_o;
  wire logic [5:0] filter_time_constant_o;
  wire logic [1:0] recovery_clock_select_o;
  wire logic [6:0] recovery_clock_mhz_o;
  wire logic [7:0] upper_bit_time_limit_o, lower_bit_time_limit_o, clamped_bit_time_o;
  // defaults from 0x39 to 0x40; both ends are unmapped and read zero
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'hA8, 8'h98, 8'h00};
  logic [3:0] gap [8] = '{4'h2, 4'hC, 4'hA, 4'h9, 4'h4, 4'h8, 4'h3, 4'h1};
  logic [7:0] gap_tc [8] = '{8'h20, 8'h20, 8'h08, 8'h08, 8'h10, 8'h10, 8'h20, 8'h20};
  logic [7:0] corner [4] = '{8'hA8, 8'hA9, 8'h97, 8'h98};
  logic [7:0] m [4];
  logic [7:0] r, v, hi, lo;
  logic [6:0] a;
  int fails = 0, checks = 0;
  wake_cdr_config_regs dut_u (.core_clk_i, .rst_n_i, .soft_reset_i, .spi_clk_i, .spi_cs_n_i,
    .spi_mosi_i, .calib_valid_i, .calib_result_high_i, .calib_result_low_i, .edge_spacing_valid_i,
    .edge_spacing_i, .measured_valid_i, .measured_bit_time_i, .spi_miso_o, .spi_miso_oe_o,
    .recovery_enable_o, .filter_time_constant_o, .recovery_clock_select_o, .recovery_clock_mhz_o,
    .upper_bit_time_limit_o, .lower_bit_time_limit_o, .clamped_bit_time_o, .clamped_valid_o);
  wake_cdr_spi_host host_u (.spi_miso_i(spi_miso_o), .spi_clk_o(spi_clk_i),
    .spi_cs_n_o(spi_cs_n_i), .spi_mosi_o(spi_mosi_i));
  // 20 MHz core clock
  always #25 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one frame: address, access bit, data byte; reply lands in r
  task automatic xf(input logic [6:0] ad, input logic acc, input logic [7:0] d);
    host_u.xfer({d, acc, ad}, r);
  endtask
  function automatic logic [7:0] tc_of(input logic [1:0] c);
    return c == 2'h0 ? 8'h08 : c == 2'h1 ? 8'h10 : 8'h20;
  endfunction
  // recovery clock rate in mhz for each select code
  function automatic logic [7:0] mhz_of(input logic [1:0] c);
    return c == 2'h0 ? 8'h50 : c == 2'h1 ? 8'h28 : c == 2'h2 ? 8'h14 : 8'h0A;
  endfunction
  function automatic logic [7:0] clamp(input logic [7:0] x);
    return x > m[2] ? m[2] : x < m[3] ? m[3] : x;
  endfunction
  task automatic check_outputs();
    check({7'h00, recovery_enable_o}, {7'h00, m[0][0]});
    if (m[0][3:2] != 2'h3) check({2'h0, filter_time_constant_o}, tc_of(m[0][3:2]));
    check({6'h00, recovery_clock_select_o}, m[1]);
    check({1'b0, recovery_clock_mhz_o}, mhz_of(m[1][1:0]));
    check(upper_bit_time_limit_o, m[2]);
    check(lower_bit_time_limit_o, m[3]);
  endtask
  task automatic measure(input logic [7:0] x);
    @(negedge core_clk_i);
    {measured_valid_i, measured_bit_time_i} = {1'b1, x};
    @(negedge core_clk_i);
    measured_valid_i = 1'b0;
    check({7'h00, clamped_valid_o}, {7'h00, m[0][0]});
    if (m[0][0]) check(clamped_bit_time_o, clamp(x));
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence; every frame waits for the previous one to end
  initial begin
    v = $urandom(32'h66AD);
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    for (int i = 0; i < 4; i++) m[i] = rst_tab[i+3];
    check_outputs();
    for (int i = 0; i < 8; i++) begin
      xf(7'h39 + i[6:0], 1'b0, 8'hFF);
      check(r, rst_tab[i]);
    end
    // calibration bytes: read, clear access, read again
    {hi, lo} = 16'($urandom);
    @(negedge core_clk_i);
    {calib_valid_i, calib_result_high_i, calib_result_low_i} = {1'b1, hi, lo};
    @(negedge core_clk_i);
    calib_valid_i = 1'b0;
    for (int i = 0; i < 6; i++) begin
      xf(7'h3A + {6'h00, i[0]}, i[2:1] == 2'h1, ~hi);
      check(r, i[0] ? lo : hi);
    end
    // random settings, each followed by a read carrying stray data
    repeat (8) begin
      a = 7'h3C + 7'($urandom % 4);
      v = 8'($urandom);
      xf(a, 1'b1, v);
      m[a-7'h3C] = v & (a == 7'h3C ? 8'h0D : a == 7'h3D ? 8'h03 : 8'hFF);
      xf(a, 1'b0, ~v);
      check(r, m[a-7'h3C]);
      check_outputs();
    end
    // fastest clock at 500k with its recommended limits, then clamp corners
    xf(7'h3D, 1'b1, 8'h00);
    xf(7'h3E, 1'b1, 8'hA8);
    xf(7'h3F, 1'b1, 8'h98);
    xf(7'h3C, 1'b1, 8'h01);
    m = '{8'h01, 8'h00, 8'hA8, 8'h98};
    check_outputs();
    for (int i = 0; i < 10; i++) measure(i < 4 ? corner[i] : 8'($urandom));
    xf(7'h3C, 1'b1, 8'h00);
    m[0] = 8'h00;
    measure(8'hFF);
    // adaptive filter; spacing outside 2..10 keeps the last constant
    xf(7'h3C, 1'b1, 8'h0D);
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk_i);
      {edge_spacing_valid_i, edge_spacing_i} = {1'b1, gap[i]};
      @(negedge core_clk_i);
      edge_spacing_valid_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      check({2'h0, filter_time_constant_o}, gap_tc[i]);
    end
    // soft reset reloads every default
    soft_reset_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    soft_reset_i = 1'b0;
    for (int i = 1; i < 7; i++) begin
      xf(7'h39 + i[6:0], 1'b0, 8'h00);
      check(r, rst_tab[i]);
    end
    print_verdict();
  end
  // the run needs well under a millisecond; a stuck frame ends it here
  initial begin
    #2000000;
    fails++;
    print_verdict();
  end
endmodule // wake_cdr_config_regs_bench
`default_nettype wire
